// >>> verilog/hwpb_cfg.svh
`ifndef HWPB_CFG_SVH
`define HWPB_CFG_SVH

// ------------------------------------------------------------
// host i/o map (byte address = base + 4 * index)
// ------------------------------------------------------------
`define HWPB_BASE_LOW      16'h0150
`define HWPB_BASE_HIGH     16'h0200
`define HWPB_HOST_SPAN     16'h0080
`define HWPB_IDX_WPORT     8'h00
`define HWPB_IDX_RPORT     8'h01
`define HWPB_IDX_FLAGS     8'h02
`define HWPB_IDX_CTRL      8'h03
`define HWPB_IDX_ID        8'h11
`define HWPB_IDX_MODE      8'h14

// ------------------------------------------------------------
// processor external memory map
// ------------------------------------------------------------
`define HWPB_HALF_LO       16'h8000
`define HWPB_FLAGS_LO      16'h9000
`define HWPB_FLAGS_HI      16'hBFFF

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define HWPB_FLG_SEND      0
`define HWPB_FLG_RECV      1
`define HWPB_FLG_BYTE      2
`define HWPB_MODE_BYTE     0
`define HWPB_CTL_RESET     0
`define HWPB_CTL_ANALYSE   1
`define HWPB_CTL_ERROR     2
`define HWPB_CTL_FTEST     3
`define HWPB_ID_PTYPE      0
`define HWPB_ID_MOFS       1

// ------------------------------------------------------------
// reset values and widths
// ------------------------------------------------------------
`define HWPB_WORD_W        16
`define HWPB_MODE_RST      1'b0
`define HWPB_CTL_RST       2'h0
`define HWPB_WORD_RST      16'h0000

`endif

// >>> verilog/hwpb_pkg.sv
package hwpb_pkg;

    // processor access sequencer, gray along idle-wait-done
    typedef enum logic [1:0] {
        PA_IDLE = 2'b00,
        PA_WAIT = 2'b01,
        PA_DONE = 2'b11
    } hwpb_pstate_type;

    typedef logic [15:0] hwpb_word_type;

endpackage

// >>> verilog/hwpb_sync.sv
`timescale 1ns/100ps

// two-stage synchroniser for pin inputs
module hwpb_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pin,
    input  wire logic [W-1:0] rst_val,
    output logic      [W-1:0] sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // meta_q feeds sync_q only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    // idle level of active-low pins is folded in after the stages
    assign sync = sync_q ^ rst_val;
endmodule

// >>> verilog/hwpb_word_port.sv
`timescale 1ns/100ps
`include "hwpb_cfg.svh"

// one-word holding port with full flag
module hwpb_word_port (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 load,
    input  wire hwpb_pkg::hwpb_word_type din,
    input  wire logic                 take,
    output hwpb_pkg::hwpb_word_type   dout,
    output logic                      full
);
    import hwpb_pkg::*;

    hwpb_word_type word_q;
    logic          full_q;

    // load sets full and wins over a take in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            word_q <= `HWPB_WORD_RST;
            full_q <= 1'b0;
        end else begin
            if (load) begin
                word_q <= din;
            end
            full_q <= load | (full_q & ~take);
        end
    end

    assign dout = word_q;
    assign full = full_q;
endmodule

// >>> verilog/hwpb_bridge.sv
// What this block does
// [RULE_01] two 16-bit host ports: write, read
// [RULE_02] processor reads in block return write port
// [RULE_03] processor writes in block fold to read port
// [RULE_04] host write waits until processor read
// [RULE_05] processor write waits until host read
// [RULE_06] every transfer moves one whole word
// [RULE_07] upper half of processor space is bridge
// [RULE_08] flags register at processor 9000-BFFF
// [RULE_09] slot 0 control from host or up port
// [RULE_10] slots 1-9 from subsystem or slot-0 source
// [RULE_11] host base 150 or 200 hex
// [RULE_12] link rate 20 or 10 Mbit/s
// [RULE_13] interrupt on channel 3, 7, or none
// [RULE_14] dma always on channel 1
// [RULE_15] factory test switches kept off
// [RULE_16] flags: send ready, receive ready, byte mode
// [RULE_17] mode bit 0 selects byte compatibility
// [RULE_18] count-prefixed blocks, at most 32 KB
// [RULE_19] both ports empty after reset
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "hwpb_cfg.svh"

module hwpb_bridge #(
    parameter logic PROC_TYPE = 1'b1
) (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    // host side, classic wishbone
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // processor external memory pins
    input  wire logic [15:0] proc_addr,
    input  wire logic        proc_rd_n,
    input  wire logic        proc_wr_n,
    input  wire logic [15:0] proc_data_i,
    output logic      [15:0] proc_data_o,
    output logic             proc_data_oe,
    output logic             proc_wait,
    // straps
    input  wire logic        slot0_control_select_switch,
    input  wire logic        upper_slots_control_select_switch,
    input  wire logic        io_base_select_switch,
    input  wire logic        link_rate_select_switch,
    input  wire logic        irq3_select_switch,
    input  wire logic        irq7_select_switch,
    input  wire logic        factory_test_switch,
    input  wire logic        factory_test_switch_b,
    // module control groups
    input  wire logic        up_reset,
    input  wire logic        up_analyse,
    output logic             up_error,
    input  wire logic        subsys_reset,
    input  wire logic        subsys_analyse,
    output logic             subsys_error,
    input  wire logic        slot0_error,
    input  wire logic        upper_error,
    output logic             slot0_reset,
    output logic             slot0_analyse,
    output logic             upper_reset,
    output logic             upper_analyse,
    // board level
    output logic             link_rate_10m,
    output logic             irq3,
    output logic             irq7,
    output logic             dma1_req
);
    import hwpb_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [33:0] pbus_s;
    logic [13:0] pins_s;
    logic [15:0] pa_s;
    logic [15:0] pd_s;
    logic        prd_s;
    logic        pwr_s;

    // strobes are active low, but their sync bits reset to 1, which prd_s and pwr_s decode as active until the stages fill
    hwpb_sync #(.W(34)) u_sync_bus (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     ({proc_addr, proc_data_i, proc_rd_n, proc_wr_n}),
        .rst_val (34'h000000003),
        .sync    (pbus_s)
    );

    hwpb_sync #(.W(14)) u_sync_pins (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .pin     ({slot0_control_select_switch, upper_slots_control_select_switch,
                   io_base_select_switch, link_rate_select_switch,
                   irq3_select_switch, irq7_select_switch,
                   factory_test_switch, factory_test_switch_b,
                   up_reset, up_analyse, subsys_reset, subsys_analyse,
                   slot0_error, upper_error}),
        .rst_val (14'h0000),
        .sync    (pins_s)
    );

    assign pa_s  = pbus_s[33:18];
    assign pd_s  = pbus_s[17:2];
    assign prd_s = ~pbus_s[1] ^ 1'b1;
    assign pwr_s = ~pbus_s[0] ^ 1'b1;

    wire sw_slot0  = pins_s[13];
    wire sw_upper  = pins_s[12];
    wire sw_base   = pins_s[11];
    wire sw_rate   = pins_s[10];
    wire sw_irq3   = pins_s[9];
    wire sw_irq7   = pins_s[8];
    wire sw_ftest  = pins_s[7] | pins_s[6];
    wire up_rst_s  = pins_s[5];
    wire up_ana_s  = pins_s[4];
    wire sub_rst_s = pins_s[3];
    wire sub_ana_s = pins_s[2];
    wire s0_err_s  = pins_s[1];
    wire up_err_s  = pins_s[0];

    // ------------------------------------------------------------
    // word ports
    // ------------------------------------------------------------
    hwpb_word_type wport_word;
    hwpb_word_type rport_word;
    logic          wport_full;
    logic          rport_full;
    logic          wport_load;
    logic          wport_take;
    logic          rport_load;
    logic          rport_take;

    // [RULE_19] ports start empty
    hwpb_word_port u_wport (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .load    (wport_load),
        .din     (wb_dat_i[15:0]),
        .take    (wport_take),
        .dout    (wport_word),
        .full    (wport_full)
    );

    hwpb_word_port u_rport (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .load    (rport_load),
        .din     (pd_s),
        .take    (rport_take),
        .dout    (rport_word),
        .full    (rport_full)
    );

    // ------------------------------------------------------------
    // host decode
    // ------------------------------------------------------------
    logic        mode_byte_q;
    logic [1:0]  ctl_q;
    logic [31:0] wb_dat_q;
    logic        wb_ack_q;

    // [RULE_11] base from strap
    wire [15:0] base    = sw_base ? `HWPB_BASE_HIGH : `HWPB_BASE_LOW;
    wire [15:0] off     = wb_adr_i - base;
    wire        in_win  = (wb_adr_i >= base) && (off < `HWPB_HOST_SPAN);
    wire [7:0]  idx     = {3'h0, off[6:2]};
    wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_q;
    wire        wr_req  = req & wb_we_i & in_win;
    wire        rd_req  = req & ~wb_we_i & in_win;
    wire        word_ok = &wb_sel_i[1:0];

    function automatic logic hit(input logic [7:0] i, input logic [7:0] k);
        hit = (i == k);
    endfunction

    // [RULE_01] write port / read port objects
    wire host_wp = wr_req & hit(idx, `HWPB_IDX_WPORT);
    wire host_rp = rd_req & hit(idx, `HWPB_IDX_RPORT);

    // [RULE_04] write to full write port holds ack back
    wire host_stall = host_wp & word_ok & wport_full;

    // [RULE_06] only whole-word writes reach the port
    assign wport_load = host_wp & word_ok & ~wport_full;
    assign rport_take = host_rp & word_ok;

    wire mode_wr = wr_req & wb_sel_i[0] & hit(idx, `HWPB_IDX_MODE);
    wire ctl_wr  = wr_req & wb_sel_i[0] & hit(idx, `HWPB_IDX_CTRL);

    // [RULE_16] flags as seen from either side
    wire [15:0] flags = {13'h0000, mode_byte_q, wport_full, ~rport_full};

    wire [15:0] ctl_rd = {12'h000, sw_ftest, s0_err_s, ctl_q};
    wire [15:0] id_rd  = {14'h0000, 1'b0, PROC_TYPE};

    wire [15:0] host_rd =
        hit(idx, `HWPB_IDX_RPORT) ? rport_word :
        hit(idx, `HWPB_IDX_FLAGS) ? flags :
        hit(idx, `HWPB_IDX_CTRL)  ? ctl_rd :
        hit(idx, `HWPB_IDX_ID)    ? id_rd : 16'h0000;

    // ack one cycle after the request, later while stalled
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end else begin
            wb_ack_q <= req & ~host_stall;
            wb_dat_q <= (rd_req & ~host_stall) ? {16'h0000, host_rd} : 32'h00000000;
        end
    end

    // [RULE_17] mode bit 0 picks byte compatibility
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode_byte_q <= `HWPB_MODE_RST;
            ctl_q       <= `HWPB_CTL_RST;
        end else begin
            if (mode_wr) begin
                mode_byte_q <= wb_dat_i[`HWPB_MODE_BYTE];
            end
            if (ctl_wr) begin
                ctl_q <= wb_dat_i[1:0];
            end
        end
    end

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;

    // ------------------------------------------------------------
    // processor decode
    // ------------------------------------------------------------
    // [RULE_07] upper half of the space belongs to the bridge
    // [RULE_18] which caps a block at 32 KB
    wire p_half  = pa_s >= `HWPB_HALF_LO;
    // [RULE_08] flags range
    wire p_flags = (pa_s >= `HWPB_FLAGS_LO) && (pa_s <= `HWPB_FLAGS_HI);
    wire p_port  = p_half & ~p_flags;

    hwpb_pstate_type ps_q;
    hwpb_pstate_type ps_d;
    logic [15:0]     pdo_q;
    logic            poe_q;
    logic            pwait_q;

    wire p_rd = prd_s & p_half;
    wire p_wr = pwr_s & p_port;

    // [RULE_02] any read in the block outside the flags range gets the write port word
    wire pread_port = (ps_q == PA_IDLE) & p_rd & p_port;
    assign wport_take = pread_port;

    // [RULE_03] any write in the block outside the flags range lands in the read port
    // [RULE_05] write waits while the read port is full
    wire pwr_go = p_wr & ~rport_full &
                  ((ps_q == PA_IDLE) | (ps_q == PA_WAIT));
    assign rport_load = pwr_go;

    wire strobe_off = ~prd_s & ~pwr_s;

    always_comb begin
        ps_d = ps_q;
        unique case (ps_q)
            PA_IDLE: begin
                if (p_rd | (pwr_s & p_half & ~p_wr) | pwr_go) begin
                    ps_d = PA_DONE;
                end else if (p_wr) begin
                    ps_d = PA_WAIT;
                end
            end
            PA_WAIT: begin
                if (pwr_go) begin
                    ps_d = PA_DONE;
                end else if (~pwr_s) begin
                    ps_d = PA_IDLE;
                end
            end
            PA_DONE: begin
                if (strobe_off) begin
                    ps_d = PA_IDLE;
                end
            end
            default: ps_d = PA_IDLE; // unused code recovers to idle
        endcase
    end

    wire [15:0] pdo_d  = p_flags ? flags : wport_word;
    wire        poe_d  = (ps_q == PA_IDLE) ? p_rd : (poe_q & prd_s);

    // sequencer and pin outputs
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ps_q    <= PA_IDLE;
            pdo_q   <= `HWPB_WORD_RST;
            poe_q   <= 1'b0;
            pwait_q <= 1'b0;
        end else begin
            ps_q    <= ps_d;
            poe_q   <= poe_d;
            pwait_q <= (ps_d == PA_WAIT);
            if (ps_q == PA_IDLE && p_rd) begin
                pdo_q <= pdo_d;
            end
        end
    end

    assign proc_data_o  = pdo_q;
    assign proc_data_oe = poe_q;
    assign proc_wait    = pwait_q;

    // ------------------------------------------------------------
    // control routing and board level outputs
    // ------------------------------------------------------------
    // [RULE_09] slot 0 source
    wire s0_rst_d = sw_slot0 ? up_rst_s : ctl_q[`HWPB_CTL_RESET];
    wire s0_ana_d = sw_slot0 ? up_ana_s : ctl_q[`HWPB_CTL_ANALYSE];
    // [RULE_10] upper slots source
    wire u_rst_d  = sw_upper ? s0_rst_d : sub_rst_s;
    wire u_ana_d  = sw_upper ? s0_ana_d : sub_ana_s;
    wire err_all  = s0_err_s | (sw_upper & up_err_s);
    // [RULE_13] interrupt routing, both on counts as disabled
    wire irq_evt  = rport_full | ~wport_full;
    // [RULE_14] dma request only in byte mode, channel 1
    wire dma_d    = mode_byte_q & rport_full;

    // [RULE_12] link rate strap
    // [RULE_15] factory test straps shown in control reg only
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            slot0_reset   <= 1'b0;
            slot0_analyse <= 1'b0;
            upper_reset   <= 1'b0;
            upper_analyse <= 1'b0;
            up_error      <= 1'b0;
            subsys_error  <= 1'b0;
            link_rate_10m <= 1'b0;
            irq3          <= 1'b0;
            irq7          <= 1'b0;
            dma1_req      <= 1'b0;
        end else begin
            slot0_reset   <= s0_rst_d;
            slot0_analyse <= s0_ana_d;
            upper_reset   <= u_rst_d;
            upper_analyse <= u_ana_d;
            up_error      <= sw_slot0 & err_all;
            subsys_error  <= ~sw_upper & up_err_s;
            link_rate_10m <= sw_rate;
            irq3          <= irq_evt & sw_irq3 & ~sw_irq7;
            irq7          <= irq_evt & sw_irq7 & ~sw_irq3;
            dma1_req      <= dma_d;
        end
    end
endmodule

// >>> dv/hwpb_bridge_assertions.sv
`timescale 1ns/100ps

// ----------------------------------------
// bridge port checker
// ----------------------------------------
module hwpb_bridge_assertions (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [15:0] proc_addr,
    input wire logic        proc_rd_n,
    input wire logic        proc_wr_n,
    input wire logic        proc_data_oe,
    input wire logic        proc_wait,
    input wire logic        link_rate_select_switch,
    input wire logic        link_rate_10m,
    input wire logic        irq3,
    input wire logic        irq7
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // upper-half read strobe held through the sync stages
    sequence s_rd_held;
        $fell(proc_rd_n) && proc_addr[15] ##1 !proc_rd_n [*3];
    endsequence

    // host read request not yet answered
    sequence s_rd_req;
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
    endsequence

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held past one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_rd_ack_next: assert property (s_rd_req |=> wb_ack_o)
        else $error("read not answered next cycle");
    a_dat_whole_word: assert property (wb_dat_o[31:16] == 16'h0 && (wb_ack_o || wb_dat_o == 32'h0))
        else $error("read data outside word or ack");
    a_oe_after_rd: assert property (s_rd_held |-> proc_data_oe)
        else $error("processor read not answered");
    a_oe_needs_rd: assert property ($rose(proc_data_oe) |-> $past(proc_rd_n, 2) == 1'h0 && $past(proc_addr, 2) >= 16'h8000)
        else $error("data driven without upper read");
    a_wait_needs_wr: assert property ($rose(proc_wait) |-> $past(proc_wr_n, 2) == 1'h0)
        else $error("wait without processor write");
    a_rate_strap: assert property (($stable(link_rate_select_switch)) [*5] |-> link_rate_10m == link_rate_select_switch)
        else $error("link rate not following strap");
    a_irq_one_line: assert property (!(irq3 && irq7))
        else $error("both interrupt lines driven");
endmodule

bind hwpb_bridge hwpb_bridge_assertions u_chk (
    .ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .proc_addr,
    .proc_rd_n, .proc_wr_n, .proc_data_oe, .proc_wait, .link_rate_select_switch,
    .link_rate_10m, .irq3, .irq7
);

// >>> dv/hwpb_proc_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// on-board processor memory master
// ----------------------------------------
module hwpb_proc_model (
    input  wire logic        ref_clk,
    output logic      [15:0] proc_addr,
    output logic             proc_rd_n,
    output logic             proc_wr_n,
    output logic      [15:0] proc_data_i,
    input  wire logic [15:0] proc_data_o,
    input  wire logic        proc_data_oe,
    input  wire logic        proc_wait
);
    // idle bus at time zero
    initial begin
        proc_addr = 16'h0000;
        proc_data_i = 16'hFFFF;
        proc_rd_n = 1'h1;
        proc_wr_n = 1'h1;
    end

    // word read: strobe held until the bridge drives data
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        proc_addr <= a;
        proc_rd_n <= 1'h0;
        do @(posedge ref_clk); while (proc_data_oe !== 1'h1);
        d = proc_data_o;
        proc_rd_n <= 1'h1;
        proc_addr <= ~a;
        repeat (4) @(posedge ref_clk);
    endtask

    // word write: released lines show inverted data
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        proc_addr <= a;
        proc_data_i <= d;
        proc_wr_n <= 1'h0;
        repeat (4) @(posedge ref_clk);
        while (proc_wait !== 1'h0) @(posedge ref_clk);
        proc_wr_n <= 1'h1;
        proc_addr <= ~a;
        proc_data_i <= ~d;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// >>> dv/hwpb_bridge_tb.sv
`timescale 1ns/100ps

module hwpb_bridge_tb;
    logic        ref_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wr_done;
    logic [15:0] wb_adr_i, proc_addr, proc_data_i, proc_data_o, base, d, pd;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        proc_rd_n, proc_wr_n, proc_data_oe, proc_wait;
    logic        slot0_control_select_switch, upper_slots_control_select_switch;
    logic        io_base_select_switch, link_rate_select_switch;
    logic        irq3_select_switch, irq7_select_switch;
    logic        factory_test_switch, factory_test_switch_b;
    logic        up_reset, up_analyse, up_error, subsys_reset, subsys_analyse;
    logic        subsys_error, slot0_error, upper_error, slot0_reset, slot0_analyse;
    logic        upper_reset, upper_analyse, link_rate_10m, irq3, irq7, dma1_req;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;

    hwpb_bridge dut (.*);
    hwpb_proc_model u_proc (.*);

    // 25 MHz clock
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    // hang guard
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_count++;
            summarize();
        end
    end

    task summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // classic wishbone single access, index addressing
    task wb_acc(input logic w, input logic [7:0] i, input logic [15:0] v);
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= base + {6'h00, i, 2'h0};
        wb_dat_i <= {16'h0000, v};
        do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
        d = wb_dat_o[15:0];
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask

    task t_reset();
        wb_acc(1'h0, 8'h02, 16'h0000);
        chk(d, 16'h0001, "flags after reset");
        chk({15'h0, proc_wait}, 16'h0000, "wait after reset");
        $display("reset done");
    endtask

    task t_host_to_proc();
        wb_acc(1'h1, 8'h00, 16'h0002);
        wb_acc(1'h0, 8'h02, 16'h0000);
        chk(d, 16'h0003, "flags with write port full");
        wr_done = 1'h0;
        fork
            begin
                wb_acc(1'h1, 8'h00, 16'hA55A);
                wr_done = 1'h1;
            end
            begin
                repeat (8) @(posedge ref_clk);
                chk({15'h0, wr_done}, 16'h0000, "host write not stalled");
                u_proc.rd(16'h8000, pd);
                chk(pd, 16'h0002, "count word");
            end
        join
        u_proc.rd(16'hFFFE, pd);
        chk(pd, 16'hA55A, "data word");
        $display("host to processor done");
    endtask

    task t_proc_to_host();
        u_proc.wr(16'h8002, 16'h1111);
        fork
            u_proc.wr(16'hC000, 16'h2222);
            begin
                repeat (8) @(posedge ref_clk);
                chk({15'h0, proc_wait}, 16'h0001, "processor not stalled");
                wb_acc(1'h0, 8'h01, 16'h0000);
                chk(d, 16'h1111, "first word");
            end
        join
        wb_acc(1'h0, 8'h01, 16'h0000);
        chk(d, 16'h2222, "second word");
        u_proc.rd(16'h9000, pd);
        chk(pd, 16'h0001, "flags at low end");
        $display("processor to host done");
    endtask

    task t_mode();
        wb_acc(1'h1, 8'h14, 16'h0001);
        u_proc.rd(16'hBFFF, pd);
        chk(pd, 16'h0005, "byte mode flag");
        u_proc.wr(16'h8000, 16'h00C3);
        chk({15'h0, dma1_req}, 16'h0001, "dma request");
        wb_acc(1'h0, 8'h01, 16'h0000);
        chk(d, 16'h00C3, "byte mode word");
        wb_acc(1'h1, 8'h14, 16'h0000);
        wb_acc(1'h0, 8'h02, 16'h0000);
        chk(d, 16'h0001, "word mode flags");
        $display("mode done");
    endtask

    task t_base();
        io_base_select_switch <= 1'h1;
        repeat (5) @(posedge ref_clk);
        base = 16'h0200;
        wb_acc(1'h1, 8'h00, 16'h1234);
        base = 16'h0150;
        wb_acc(1'h0, 8'h02, 16'h0000);
        chk(d, 16'h0000, "old base answers");
        base = 16'h0200;
        wb_acc(1'h0, 8'h02, 16'h0000);
        chk(d, 16'h0003, "flags at high base");
        u_proc.rd(16'h8000, pd);
        chk(pd, 16'h1234, "word via high base");
        io_base_select_switch <= 1'h0;
        repeat (5) @(posedge ref_clk);
        base = 16'h0150;
        $display("base select done");
    endtask

    task t_straps();
        for (int k = 0; k < 4; k++) begin
            irq3_select_switch <= k[0];
            irq7_select_switch <= k[1];
            repeat (5) @(posedge ref_clk);
            chk({14'h0, irq7, irq3}, {14'h0, k[1] & ~k[0], k[0] & ~k[1]}, "irq route");
        end
        link_rate_select_switch <= 1'h1;
        repeat (5) @(posedge ref_clk);
        chk({15'h0, link_rate_10m}, 16'h0001, "link rate");
        link_rate_select_switch <= 1'h0;
        wb_acc(1'h1, 8'h03, 16'h0001);
        repeat (3) @(posedge ref_clk);
        chk({14'h0, upper_reset, slot0_reset}, 16'h0003, "host reset");
        upper_slots_control_select_switch <= 1'h0;
        repeat (5) @(posedge ref_clk);
        chk({14'h0, upper_reset, slot0_reset}, 16'h0001, "subsystem source");
        slot0_control_select_switch <= 1'h1;
        up_reset <= 1'h1;
        repeat (5) @(posedge ref_clk);
        wb_acc(1'h1, 8'h03, 16'h0000);
        repeat (3) @(posedge ref_clk);
        chk({15'h0, slot0_reset}, 16'h0001, "up port source");
        up_analyse <= 1'h1;
        slot0_error <= 1'h1;
        upper_error <= 1'h1;
        repeat (5) @(posedge ref_clk);
        chk({14'h0, slot0_analyse, upper_analyse}, 16'h0002, "analyse routing");
        chk({14'h0, up_error, subsys_error}, 16'h0003, "error routing");
        wb_acc(1'h0, 8'h03, 16'h0000);
        chk(d, 16'h0004, "slot 0 error to host");
        $display("straps done");
    endtask

    // reset, then the scenarios
    initial begin
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {slot0_control_select_switch, io_base_select_switch, link_rate_select_switch} = '0;
        {irq7_select_switch, up_reset, up_analyse, subsys_reset, subsys_analyse} = '0;
        {slot0_error, upper_error} = '0;
        {factory_test_switch, factory_test_switch_b} = '0;
        upper_slots_control_select_switch = 1'h1;
        irq3_select_switch = 1'h1;
        wb_sel_i = 4'hF;
        base = 16'h0150;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_host_to_proc();
        t_proc_to_host();
        t_mode();
        t_base();
        t_straps();
        summarize();
    end
endmodule
